// ---- shared/spi_map_pkg.sv ----
// Shared constants and types for the mapped flash read sequencer
`default_nettype none
package spi_map_pkg;
  // Register byte offsets on the APB window
  localparam logic [7:0] OFS_MAPPED_READ_COMMAND = 8'h00;
  localparam logic [7:0] OFS_MAPPED_READ_ENABLE = 8'h04;
  localparam logic [7:0] OFS_MAPPED_READ_OPTION = 8'h08;
  localparam logic [7:0] OFS_MAPPED_READ_DUMMY = 8'h0C;
  localparam logic [7:0] OFS_BIT_RATE = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;
  // Reset values
  localparam logic [7:0] COMMAND_RST = 8'h03;
  localparam logic [31:0] ENABLE_RST = 32'h0000_0070;
  localparam logic [31:0] OPTION_RST = 32'h0000_0000;
  localparam logic [31:0] DUMMY_RST = 32'h0000_0000;
  localparam logic [9:0] RATE_RST = 10'h001;
  // Enable register fields
  localparam int EN_CMD_WIDTH_LSB = 0;
  localparam int EN_ADDR_WIDTH_LSB = 2;
  localparam int EN_ADDR_LEN_LSB = 4;
  localparam int EN_OPT_SEL_LSB = 8;
  localparam int EN_OPT_WIDTH_LSB = 12;
  localparam int EN_DUMMY_EN_BIT = 14;
  localparam int EN_READ_WIDTH_LSB = 16;
  // Dummy register fields
  localparam int DM_COUNT_LSB = 0;
  localparam int DM_WIDTH_LSB = 16;
  // Bit rate register fields
  localparam int RATE_VALUE_LSB = 0;
  localparam int RATE_DIV_LSB = 8;
  // Field encodings
  localparam logic [1:0] WIDTH_QUAD = 2'h2;
  localparam logic [3:0] ADDR_LEN_24 = 4'h7;
  localparam logic [3:0] ADDR_LEN_32 = 4'hF;
  localparam logic [3:0] OPT_SEL_3 = 4'h8;
  localparam logic [3:0] OPT_SEL_32 = 4'hC;
  localparam logic [3:0] OPT_SEL_321 = 4'hE;
  localparam logic [3:0] OPT_SEL_3210 = 4'hF;
  // Timing and sizes
  localparam logic [11:0] HALF_MIN = 12'h002;
  localparam logic [5:0] DATA_BITS = 6'h20;
  localparam int FIFO_WIDTH = 8;
  localparam int FIFO_DEPTH = 4;

  // Sequencer phases in transfer order
  typedef enum logic [2:0] {
    PH_IDLE, PH_CMD, PH_ADDR, PH_OPT, PH_DUMMY, PH_DATA, PH_DONE
  } phase_t;

  // True when a two-bit width setting asks for four lines
  function automatic logic is_quad(input logic [1:0] w);
    is_quad = (w == WIDTH_QUAD);
  endfunction : is_quad

  // Number of option bytes that a select code enables
  function automatic logic [2:0] opt_count(input logic [3:0] sel);
    case (sel)
      OPT_SEL_3: opt_count = 3'h1;
      OPT_SEL_32: opt_count = 3'h2;
      OPT_SEL_321: opt_count = 3'h3;
      OPT_SEL_3210: opt_count = 3'h4;
      default: opt_count = 3'h0;
    endcase
  endfunction : opt_count
endpackage : spi_map_pkg
`default_nettype wire

// ---- shared/fifo_link_if.sv ----
// Push and pop handshake between the sequencer and its read FIFO
`timescale 1ns/10ps
`default_nettype none
interface fifo_link_if #(parameter int WIDTH = 8);
  logic push_valid; // Byte offered by the sequencer
  logic push_ready; // FIFO has room
  logic [WIDTH-1:0] push_data; // Byte being offered
  logic pop_valid; // FIFO holds a byte
  logic pop_ready; // Consumer takes the byte
  logic [WIDTH-1:0] pop_data; // Oldest byte

  // FIFO side
  modport store (
    input push_valid, push_data, pop_ready,
    output push_ready, pop_valid, pop_data
  );
  // Sequencer and consumer side
  modport user (
    output push_valid, push_data, pop_ready,
    input push_ready, pop_valid, pop_data
  );
endinterface : fifo_link_if
`default_nettype wire

// ---- core/byte_fifo.sv ----
// Small synchronous FIFO for bytes read from the flash
`timescale 1ns/10ps
`default_nettype none
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // Both handshake sides
  fifo_link_if.store link
);
  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  // Whole FIFO state, storage included
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0] wptr;
    logic [PW-1:0] rptr;
    logic [CW-1:0] count;
  } fifo_state_t;

  fifo_state_t s_r; // Registered state
  fifo_state_t s_nxt; // Next state
  logic push; // Write this cycle
  logic pop; // Read this cycle

  // Honest flags straight from the fill level
  assign link.push_ready = (s_r.count != CW'(DEPTH));
  assign link.pop_valid = (s_r.count != '0);
  assign link.pop_data = s_r.mem[s_r.rptr];
  assign push = link.push_valid && link.push_ready;
  assign pop = link.pop_valid && link.pop_ready;

  // Pointer and level update; wrap kept general for any depth
  always_comb begin
    s_nxt = s_r;
    if (push) begin
      s_nxt.mem[s_r.wptr] = link.push_data;
      s_nxt.wptr = (s_r.wptr == PW'(DEPTH - 1)) ? '0 : s_r.wptr + 1'b1;
    end
    if (pop) begin
      s_nxt.rptr = (s_r.rptr == PW'(DEPTH - 1)) ? '0 : s_r.rptr + 1'b1;
    end
    s_nxt.count = s_r.count + CW'(push) - CW'(pop);
  end

  // State register
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end
endmodule : byte_fifo
`default_nettype wire

// ---- core/spi_flash_mapped_read.sv ----
// Mapped read sequencer: bus reads become serial flash read transfers
`timescale 1ns/10ps
`default_nettype none
// Operation
// RL1: Send 8-bit read command code first
// RL2: Command phase on one or four lines
// RL3: Hold four programmable option bytes
// RL4: Select none, 3, 32, 321 or 3210
// RL5: Option bytes on one or four lines
// RL6: Dummy count code gives one to eight
// RL7: Dummy enable bit can skip dummies
// RL8: Dummy phase on one or four lines
// RL9: Read data on one or four lines
// RL10: Address 24 or 32 bits, selectable width
// RL11: Clock rate from value and divider
// RL12: Phase order fixed, select held throughout
// RL13: Flash drives data only in data phase
module spi_flash_mapped_read (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // APB register port
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Mapped read request
  input wire logic mem_req,
  input wire logic [31:0] mem_addr,
  output logic mem_accept,
  // Read data stream
  output logic mem_rvalid,
  output logic [spi_map_pkg::FIFO_WIDTH-1:0] mem_rdata,
  input wire logic mem_rready,
  // Flash pins
  output logic flash_serial_clock,
  output logic flash_slave_select_n,
  output logic [3:0] flash_io_out,
  output logic [3:0] flash_io_oe_n,
  input wire logic [3:0] flash_io_in
);
  import spi_map_pkg::*;

  // Shift pattern and clock count that a phase starts with
  typedef struct packed {
    logic [31:0] shift;
    logic [5:0] clks;
  } load_t;

  // All state of the block
  typedef struct packed {
    logic [7:0] read_cmd; // Command register
    logic [31:0] enr; // Enable register
    logic [31:0] opt; // Option bytes
    logic [31:0] dmy; // Dummy register
    logic [9:0] rate; // Bit rate register
    logic [31:0] prdata; // Read data for the access phase
    logic pslverr; // Error for the access phase
    phase_t phase; // Sequencer phase
    logic [31:0] addr; // Captured mapped address
    logic [31:0] shift; // Outgoing bits, MSB first
    logic [5:0] clks; // Serial clocks left in phase
    logic [11:0] div_cnt; // Half period down counter
    logic sclk; // Serial clock level
    logic ssl_n; // Slave select, low active
    logic [3:0] io_out; // Line values
    logic [3:0] oe_n; // Line enables, low drives
    logic [7:0] rx; // Byte being received
    logic [3:0] bits_in; // Bits of rx filled
    logic rx_valid; // Byte waiting for the FIFO
    logic [3:0] sync1; // First synchroniser stage
    logic [3:0] sync2; // Second synchroniser stage
  } seq_state_t;

  localparam seq_state_t ST_RST = '{
    read_cmd: COMMAND_RST, enr: ENABLE_RST, opt: OPTION_RST,
    dmy: DUMMY_RST, rate: RATE_RST, phase: PH_IDLE, ssl_n: 1'b1,
    oe_n: 4'hF, default: '0
  };

  seq_state_t s_r; // Registered state
  seq_state_t s_nxt; // Next state
  logic [11:0] half; // Half period in mclk cycles
  logic cur_quad; // Current phase uses four lines
  logic nxt_quad; // Next phase uses four lines
  logic addr_ok; // APB address decodes
  phase_t np; // Phase after the current one
  load_t ld; // Load for a starting phase

  fifo_link_if #(.WIDTH(FIFO_WIDTH)) rx_link ();

  // Width setting that governs a phase
  function automatic logic [1:0] lane_sel(input phase_t p,
                                          input logic [31:0] enr,
                                          input logic [31:0] dmy);
    case (p)
      // RL2 command lines
      PH_CMD: lane_sel = enr[EN_CMD_WIDTH_LSB +: 2];
      // RL10 address lines
      PH_ADDR: lane_sel = enr[EN_ADDR_WIDTH_LSB +: 2];
      // RL5 option lines
      PH_OPT: lane_sel = enr[EN_OPT_WIDTH_LSB +: 2];
      // RL8 dummy lines
      PH_DUMMY: lane_sel = dmy[DM_WIDTH_LSB +: 2];
      // RL9 read lines
      PH_DATA: lane_sel = enr[EN_READ_WIDTH_LSB +: 2];
      default: lane_sel = 2'h0;
    endcase
  endfunction : lane_sel

  // Next enabled phase; skipped phases fall through
  function automatic phase_t next_phase(input phase_t p,
                                        input logic [31:0] enr);
    logic addr_on;
    logic opt_on;
    logic dmy_on;
    addr_on = (enr[EN_ADDR_LEN_LSB +: 4] == ADDR_LEN_24) ||
              (enr[EN_ADDR_LEN_LSB +: 4] == ADDR_LEN_32);
    opt_on = (opt_count(enr[EN_OPT_SEL_LSB +: 4]) != 3'h0);
    // RL7 dummy enable gate
    dmy_on = enr[EN_DUMMY_EN_BIT];
    // RL12 fixed phase order
    if (p == PH_CMD && addr_on) next_phase = PH_ADDR;
    else if ((p == PH_CMD || p == PH_ADDR) && opt_on) next_phase = PH_OPT;
    else if (p != PH_DUMMY && p != PH_DATA && dmy_on) next_phase = PH_DUMMY;
    else if (p != PH_DATA) next_phase = PH_DATA;
    else next_phase = PH_DONE;
  endfunction : next_phase

  // Shift pattern and clock count for a starting phase
  function automatic load_t load_phase(input phase_t p,
                                       input logic [31:0] addr,
                                       input logic [7:0] cmd,
                                       input logic [31:0] enr,
                                       input logic [31:0] opt,
                                       input logic [31:0] dmy);
    load_t r;
    logic [5:0] bits;
    logic q;
    r = '0;
    bits = 6'h00;
    q = is_quad(lane_sel(p, enr, dmy));
    case (p)
      PH_CMD: begin
        // RL1 command code first
        r.shift = {cmd, 24'h00_0000};
        bits = 6'h08;
      end
      PH_ADDR: begin
        // RL10 address length
        if (enr[EN_ADDR_LEN_LSB +: 4] == ADDR_LEN_32) begin
          r.shift = addr;
          bits = 6'h20;
        end else begin
          r.shift = {addr[23:0], 8'h00};
          bits = 6'h18;
        end
      end
      PH_OPT: begin
        // RL4 byte three leads
        r.shift = opt;
        bits = {opt_count(enr[EN_OPT_SEL_LSB +: 4]), 3'h0};
      end
      PH_DUMMY: begin
        // RL6 code plus one clocks
        bits = {3'h0, dmy[DM_COUNT_LSB +: 3]} + 6'h01;
      end
      PH_DATA: bits = DATA_BITS;
      default: bits = 6'h00;
    endcase
    // Dummy counts clocks, every other phase counts bits
    r.clks = (q && p != PH_DUMMY) ? {2'h0, bits[5:2]} : bits;
    return r;
  endfunction : load_phase

  // Register file decode
  assign addr_ok = (paddr == OFS_MAPPED_READ_COMMAND) ||
                   (paddr == OFS_MAPPED_READ_ENABLE) ||
                   (paddr == OFS_MAPPED_READ_OPTION) ||
                   (paddr == OFS_MAPPED_READ_DUMMY) ||
                   (paddr == OFS_BIT_RATE) || (paddr == OFS_STATUS);

  // RL11 half period from rate value and divider, floored for sync delay
  always_comb begin
    half = ({4'h0, s_r.rate[RATE_VALUE_LSB +: 8]} + 12'h001)
           << s_r.rate[RATE_DIV_LSB +: 2];
    if (half < HALF_MIN) begin
      half = HALF_MIN;
    end
  end

  // Whole next state of the sequencer and register file
  always_comb begin
    s_nxt = s_r;
    np = PH_IDLE;
    ld = '0;
    cur_quad = is_quad(lane_sel(s_r.phase, s_r.enr, s_r.dmy));
    // Flash lines come from another timing world
    s_nxt.sync1 = flash_io_in;
    s_nxt.sync2 = s_r.sync1;
    // Setup cycle prepares read data so the access phase needs no wait
    if (psel && !penable) begin
      s_nxt.pslverr = !addr_ok;
      case (paddr)
        OFS_MAPPED_READ_COMMAND: s_nxt.prdata = {24'h00_0000, s_r.read_cmd};
        OFS_MAPPED_READ_ENABLE: s_nxt.prdata = s_r.enr;
        // RL3 option bytes readable
        OFS_MAPPED_READ_OPTION: s_nxt.prdata = s_r.opt;
        OFS_MAPPED_READ_DUMMY: s_nxt.prdata = s_r.dmy;
        OFS_BIT_RATE: s_nxt.prdata = {22'h00_0000, s_r.rate};
        OFS_STATUS: s_nxt.prdata = {29'h0000_0000, rx_link.pop_valid,
                                    s_r.rx_valid,
                                    (s_r.phase != PH_IDLE)};
        default: s_nxt.prdata = 32'h0000_0000;
      endcase
    end
    // Writes land at the access edge only
    if (psel && penable && pwrite && addr_ok) begin
      case (paddr)
        OFS_MAPPED_READ_COMMAND: s_nxt.read_cmd = pwdata[7:0];
        OFS_MAPPED_READ_ENABLE: s_nxt.enr = pwdata;
        // RL3 four option bytes stored
        OFS_MAPPED_READ_OPTION: s_nxt.opt = pwdata;
        OFS_MAPPED_READ_DUMMY: s_nxt.dmy = pwdata;
        OFS_BIT_RATE: s_nxt.rate = pwdata[9:0];
        default: s_nxt.rate = s_r.rate;
      endcase
    end
    // Received byte leaves once the FIFO takes it
    if (s_r.rx_valid && rx_link.push_ready) begin
      s_nxt.rx_valid = 1'b0;
    end
    case (s_r.phase)
      PH_IDLE: begin
        s_nxt.sclk = 1'b0;
        s_nxt.ssl_n = 1'b1;
        if (mem_req) begin
          // RL12 select falls at start
          ld = load_phase(PH_CMD, mem_addr, s_r.read_cmd, s_r.enr,
                          s_r.opt, s_r.dmy);
          s_nxt.addr = mem_addr;
          s_nxt.ssl_n = 1'b0;
          s_nxt.phase = PH_CMD;
          s_nxt.shift = ld.shift;
          s_nxt.clks = ld.clks;
          s_nxt.bits_in = 4'h0;
          s_nxt.div_cnt = half - 12'h001;
        end
      end
      PH_DONE: begin
        // Wait for the last byte to reach the FIFO
        s_nxt.ssl_n = 1'b1;
        if (!s_r.rx_valid) begin
          s_nxt.phase = PH_IDLE;
        end
      end
      default: begin
        if (s_r.div_cnt != 12'h000) begin
          s_nxt.div_cnt = s_r.div_cnt - 12'h001;
        end else if (!s_r.rx_valid) begin
          // Clock stops low while the FIFO is full
          s_nxt.div_cnt = half - 12'h001;
          if (!s_r.sclk) begin
            s_nxt.sclk = 1'b1;
          end else begin
            s_nxt.sclk = 1'b0;
            // RL13 sample only in data phase
            if (s_r.phase == PH_DATA) begin
              // RL9 one or four bits per clock
              if (cur_quad) begin
                s_nxt.rx = {s_r.rx[3:0], s_r.sync2};
                s_nxt.bits_in = s_r.bits_in + 4'h4;
              end else begin
                s_nxt.rx = {s_r.rx[6:0], s_r.sync2[1]};
                s_nxt.bits_in = s_r.bits_in + 4'h1;
              end
              if (s_nxt.bits_in == 4'h8) begin
                s_nxt.bits_in = 4'h0;
                s_nxt.rx_valid = 1'b1;
              end
            end
            if (s_r.clks == 6'h01) begin
              // RL12 advance to next phase
              np = next_phase(s_r.phase, s_r.enr);
              ld = load_phase(np, s_r.addr, s_r.read_cmd, s_r.enr,
                              s_r.opt, s_r.dmy);
              s_nxt.phase = np;
              s_nxt.shift = ld.shift;
              s_nxt.clks = ld.clks;
              s_nxt.ssl_n = (np == PH_DONE);
            end else begin
              s_nxt.clks = s_r.clks - 6'h01;
              s_nxt.shift = cur_quad ? (s_r.shift << 4) : (s_r.shift << 1);
            end
          end
        end
      end
    endcase
    // Line drive follows the phase now in force
    nxt_quad = is_quad(lane_sel(s_nxt.phase, s_nxt.enr, s_nxt.dmy));
    case (s_nxt.phase)
      PH_CMD, PH_ADDR, PH_OPT, PH_DUMMY: begin
        if (nxt_quad) begin
          s_nxt.io_out = (s_nxt.phase == PH_DUMMY) ? 4'h0
                         : s_nxt.shift[31:28];
          s_nxt.oe_n = 4'h0;
        end else begin
          s_nxt.io_out = {3'h0,
                          (s_nxt.phase != PH_DUMMY) && s_nxt.shift[31]};
          s_nxt.oe_n = 4'hE;
        end
      end
      default: begin
        // RL13 lines released for the flash
        s_nxt.io_out = 4'h0;
        s_nxt.oe_n = 4'hF;
      end
    endcase
  end

  // State register
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      s_r <= ST_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Read FIFO between sequencer and consumer
  byte_fifo #(
    .WIDTH(FIFO_WIDTH),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .mclk(mclk),
    .reset_n(reset_n),
    .link(rx_link.store)
  );

  assign rx_link.push_valid = s_r.rx_valid;
  assign rx_link.push_data = s_r.rx;
  assign rx_link.pop_ready = mem_rready;

  // Outputs
  assign prdata = s_r.prdata;
  assign pslverr = s_r.pslverr;
  assign pready = 1'b1;
  assign mem_accept = (s_r.phase == PH_IDLE) && mem_req;
  assign mem_rvalid = rx_link.pop_valid;
  assign mem_rdata = rx_link.pop_data;
  assign flash_serial_clock = s_r.sclk;
  assign flash_slave_select_n = s_r.ssl_n;
  assign flash_io_out = s_r.io_out;
  assign flash_io_oe_n = s_r.oe_n;
endmodule : spi_flash_mapped_read
`default_nettype wire

// ---- verification/spi_flash_mapped_read_chk.sv ----
// Assertions for the mapped flash read sequencer
`timescale 1ns/10ps
`default_nettype none
module spi_flash_mapped_read_chk (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // Mapped read side
  input wire logic mem_accept,
  input wire logic mem_rvalid,
  input wire logic [spi_map_pkg::FIFO_WIDTH-1:0] mem_rdata,
  input wire logic mem_rready,
  // Flash pins
  input wire logic flash_serial_clock,
  input wire logic flash_slave_select_n,
  input wire logic [3:0] flash_io_oe_n
);
  import spi_map_pkg::*;
  // One clock domain
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  // Start of a frame
  sequence frame_open;
    $fell(flash_slave_select_n);
  endsequence
  // Select stays low for at least eight cycles
  sequence held_low;
    !flash_slave_select_n [*8];
  endsequence

  AST_IDLE_RELEASED: assert property (flash_slave_select_n |->
    flash_io_oe_n == 4'hF && !flash_serial_clock)
    else $error("lines or clock active while idle");
  AST_ACCEPT_OPENS: assert property (mem_accept |=>
    !flash_slave_select_n) else $error("no select after accept");
  AST_BUSY_REFUSES: assert property (!flash_slave_select_n |->
    !mem_accept) else $error("accept inside a frame");
  AST_FIRST_CMD: assert property (frame_open |->
    flash_io_oe_n != 4'hF && !flash_serial_clock)
    else $error("command not driven at start");
  AST_SELECT_HELD: assert property (frame_open |-> held_low)
    else $error("select released too early");
  AST_WIDTH_CODES: assert property (!flash_slave_select_n |->
    flash_io_oe_n inside {4'hE, 4'h0, 4'hF})
    else $error("line enables not single or quad");
  AST_SCLK_HALF: assert property ($changed(flash_serial_clock) |=>
    $stable(flash_serial_clock)) else $error("clock half under two cycles");
  AST_SCLK_FRAMED: assert property (flash_serial_clock |->
    !flash_slave_select_n) else $error("clock outside a frame");
  AST_DATA_RELEASE: assert property (!flash_slave_select_n &&
    flash_io_oe_n == 4'hF |=> flash_io_oe_n == 4'hF)
    else $error("lines driven after data phase began");
  AST_STREAM_HOLD: assert property (mem_rvalid && !mem_rready |=>
    mem_rvalid && $stable(mem_rdata)) else $error("stream byte lost");
endmodule : spi_flash_mapped_read_chk

bind spi_flash_mapped_read spi_flash_mapped_read_chk chk (.mclk, .reset_n,
  .mem_accept, .mem_rvalid, .mem_rdata, .mem_rready, .flash_serial_clock,
  .flash_slave_select_n, .flash_io_oe_n);
`default_nettype wire

// ---- verification/flash_model.sv ----
// Serial flash partner model
`timescale 1ns/10ps
`default_nettype none
module flash_model (
  // Pins seen from the flash
  input wire logic mclk,
  input wire logic sclk,
  input wire logic select_n,
  input wire logic [3:0] io,
  // Setup from the bench
  input wire logic [31:0] word,
  input wire logic quad,
  input wire logic [7:0] pre,
  // Lines driven back
  output logic [3:0] drv
);
  logic [3:0] log [0:127]; // Lines at each rise
  logic [3:0] dq = 4'h0; // Next data unit
  logic on = 1'b0; // Flash owns the lines
  int rises = 0; // Rises this frame
  int falls = 0; // Falls this frame
  int idx; // Data unit in flight
  realtime t_rise = 0.0; // Last rise
  realtime period = 0.0; // Last period

  initial drv = 4'h0;
  // New frame
  always @(negedge select_n) begin
    rises = 0;
    falls = 0;
  end
  // Lines as the flash samples them
  always @(posedge sclk) begin
    log[rises[6:0]] = io;
    if (rises > 0) period = $realtime - t_rise;
    t_rise = $realtime;
    rises = rises + 1;
  end
  always @(negedge sclk) begin
    falls = falls + 1;
    idx = falls - pre;
    on = !select_n && falls >= pre && idx < (quad ? 8 : 32);
    if (quad) dq = word[31 - 4 * idx -: 4];
    else dq = {2'b00, word[31 - idx], 1'b0};
  end
  // Released lines toggle so stale values never pass
  always @(posedge mclk) begin
    if (on && quad) drv <= dq;
    else if (on) drv <= {~drv[3:2], dq[1], ~drv[0]};
    else drv <= ~drv;
  end
endmodule : flash_model
`default_nettype wire

// ---- verification/spi_flash_mapped_read_tb.sv ----
// Bench for the mapped flash read sequencer
`timescale 1ns/10ps
`default_nettype none
module spi_flash_mapped_read_tb;
  import spi_map_pkg::*;
  localparam logic [31:0] OPT_VAL = 32'hA53C_960F; // Option bytes 3..0
  logic mclk = 1'b0; // System clock
  logic reset_n = 1'b0; // Active low reset
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0; // APB controls
  logic [7:0] paddr = 8'h00; // APB address
  logic [31:0] pwdata = 32'h0000_0000, prdata; // APB data
  logic pready, pslverr; // APB answer
  logic mem_req = 1'b0, mem_accept, mem_rvalid, mem_rready = 1'b1;
  logic [31:0] mem_addr = 32'h0000_0000; // Mapped address
  logic [FIFO_WIDTH-1:0] mem_rdata; // Stream byte
  logic sclk, sel_n; // Flash clock and select
  logic [3:0] io_out, io_oe_n, io_in, drv; // Flash lines
  logic [31:0] word = 32'h0000_0000; // Flash data word
  logic quad = 1'b0; // Quad data
  logic [7:0] pre = 8'h00; // Clocks before data
  int failures = 0, total_checks = 0; // Counters
  logic [4:0] exq [$]; // Expected units

  // Line shows whoever drives it
  assign io_in = (~io_oe_n & io_out) | (io_oe_n & drv);
  always #20 mclk = ~mclk;

  spi_flash_mapped_read DUT (.mclk(mclk), .reset_n(reset_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .mem_req(mem_req),
    .mem_addr(mem_addr), .mem_accept(mem_accept), .mem_rvalid(mem_rvalid),
    .mem_rdata(mem_rdata), .mem_rready(mem_rready),
    .flash_serial_clock(sclk), .flash_slave_select_n(sel_n),
    .flash_io_out(io_out), .flash_io_oe_n(io_oe_n), .flash_io_in(io_in));
  flash_model fm (.mclk(mclk), .sclk(sclk), .select_n(sel_n), .io(io_in),
    .word(word), .quad(quad), .pre(pre), .drv(drv));

  // Verdict for both endings
  task automatic results;
    $display("checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : results

  // Compare and count
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : check

  // One APB transfer held until pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] q, output logic e);
    int k;
    k = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask : wr

  // Read one register, judge data and error flag
  task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic f);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h0000_0000, q, e);
    check(q, x);
    check(e, f);
  endtask : rd

  // Hold the request until taken
  task automatic req(input logic [31:0] a);
    int k;
    k = 0;
    mem_addr <= a;
    mem_req <= 1'b1;
    do begin
      @(negedge mclk);
      k++;
    end while (mem_accept !== 1'b1 && k < 3000);
    check(k < 3000, 1'b1);
    @(posedge mclk);
    mem_req <= 1'b0;
  endtask : req

  // Take n stream bytes mid-cycle, where settled
  task automatic pops(input int n);
    int k;
    for (int b = 0; b < n; b++) begin
      k = 0;
      @(negedge mclk);
      while (mem_rvalid !== 1'b1 && k < 3000) begin
        @(negedge mclk);
        k++;
      end
      check(mem_rdata, word[31 - 8 * (b % 4) -: 8]);
      @(posedge mclk);
    end
  endtask : pops

  // Expected units of a field, MSB first
  task automatic add(input logic [31:0] v, input int n, input logic q);
    if (q) begin
      for (int i = n / 4 - 1; i >= 0; i--) exq.push_back({1'b1, v[4*i +: 4]});
    end else begin
      for (int i = n - 1; i >= 0; i--) exq.push_back({4'h0, v[i]});
    end
  endtask : add

  // Configure, read one word, judge each phase
  task automatic xfer(input logic [7:0] cmd, input logic [31:0] en,
    input logic [31:0] dm, input logic [9:0] rate, input logic [31:0] a);
    int n;
    exq.delete();
    wr(OFS_MAPPED_READ_COMMAND, {24'h00_0000, cmd});
    wr(OFS_MAPPED_READ_ENABLE, en);
    wr(OFS_MAPPED_READ_DUMMY, dm);
    wr(OFS_BIT_RATE, {22'h00_0000, rate});
    add({24'h00_0000, cmd}, 8, en[1:0] == WIDTH_QUAD);
    if (en[7:4] inside {ADDR_LEN_24, ADDR_LEN_32})
      add(a, en[7] ? 32 : 24, en[3:2] == WIDTH_QUAD);
    n = $countones(en[11:8]);
    for (int i = 0; i < n; i++) add(OPT_VAL >> 24 - 8 * i, 8, en[13:12] == 2);
    if (en[EN_DUMMY_EN_BIT]) begin
      for (int i = 0; i <= dm[2:0]; i++)
        exq.push_back({dm[17:16] == 2, 4'h0});
    end
    word <= a ^ 32'h5A3C_96E1;
    quad <= (en[17:16] == WIDTH_QUAD);
    pre <= 8'(exq.size());
    req(a);
    pops(4);
    check(fm.rises, exq.size() + (quad ? 8 : 32));
    for (int i = 0; i < exq.size(); i++) begin
      if (exq[i][4]) check(fm.log[i], exq[i][3:0]);
      else check(fm.log[i][0], exq[i][0]);
    end
    check($rtoi(fm.period), 80 * ((rate[7:0] + 1) << rate[9:8]));
  endtask : xfer

  // Reset values, options, unmapped address
  task automatic t_regs;
    rd(OFS_MAPPED_READ_COMMAND, {24'h00_0000, COMMAND_RST}, 1'b0);
    rd(OFS_MAPPED_READ_ENABLE, ENABLE_RST, 1'b0);
    rd(OFS_MAPPED_READ_DUMMY, DUMMY_RST, 1'b0);
    rd(OFS_BIT_RATE, {22'h00_0000, RATE_RST}, 1'b0);
    rd(OFS_MAPPED_READ_OPTION, OPTION_RST, 1'b0);
    wr(OFS_MAPPED_READ_OPTION, OPT_VAL);
    rd(OFS_MAPPED_READ_OPTION, OPT_VAL, 1'b0);
    rd(8'h18, 32'h0000_0000, 1'b1);
  endtask : t_regs

  // FIFO fills, clock parks low, then drains in order
  task automatic t_stall;
    logic [31:0] q;
    logic e;
    int k;
    k = 0;
    mem_rready <= 1'b0;
    wr(OFS_MAPPED_READ_ENABLE, ENABLE_RST);
    word <= 32'h0F1E_2D3C;
    quad <= 1'b0;
    pre <= 8'h20;
    req(32'h0000_0100);
    req(32'h0000_0200);
    do begin
      apb(1'b0, OFS_STATUS, 32'h0000_0000, q, e);
      k++;
    end while (q[1] !== 1'b1 && k < 500);
    check({q[2:0], sclk, sel_n}, 32'h0000_001C);
    mem_rready <= 1'b1;
    pops(8);
  endtask : t_stall

  // Main sequence
  initial begin
    repeat (4) @(posedge mclk);
    reset_n <= 1'b1;
    @(posedge mclk);
    t_regs();
    xfer(8'h03, ENABLE_RST, 32'h0000_0000, 10'h003, 32'h0012_3456);
    xfer(8'hEB, 32'h0002_6FFA, 32'h0002_0007, 10'h103, 32'h89AB_CDEF);
    xfer(8'h0B, 32'h0000_4870, 32'h0000_0000, 10'h003, 32'h0000_0FF0);
    xfer(8'h6B, 32'h0002_2C70, 32'h0002_0005, 10'h003, 32'h00C0_FFEE);
    xfer(8'h3B, 32'h0000_4EF0, 32'h0002_0002, 10'h003, 32'h7654_3210);
    t_stall();
    results();
  end
  // Watchdog
  initial begin
    #1_000_000;
    failures++;
    results();
  end
endmodule : spi_flash_mapped_read_tb
`default_nettype wire
